// ==== common/pllcg_defines.vh ====
// Purpose: Constants for the PLL clock generator register block
// Assumes: AXI4-Lite register access, one 32-bit word per register
// Notes:   Register contents are 8 bits wide, upper bus bits read as zero
`ifndef PLLCG_DEFINES_VH
`define PLLCG_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PLLCG_ADDR_W        4
`define PLLCG_OFS_CTRL      4'h0
`define PLLCG_OFS_BW        4'h4
`define PLLCG_OFS_PROG      4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLLCG_CTRL_IE       7
`define PLLCG_CTRL_FLAG     6
`define PLLCG_CTRL_PWR      5
`define PLLCG_CTRL_SEL      4
`define PLLCG_CTRL_ONES     4'hF
`define PLLCG_BW_AUTO       7
`define PLLCG_BW_LOCK       6
`define PLLCG_BW_ACQ        5
`define PLLCG_BW_XLD        4
`define PLLCG_BW_RSVD       4'h0
`define PLLCG_PROG_MUL      7:4
`define PLLCG_PROG_RNG      3:0
`define PLLCG_BUS_BYTE      7:0
`define PLLCG_STRB_LOW      0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define PLLCG_MUL_RST       4'h6
`define PLLCG_RNG_RST       4'h6
`define PLLCG_NIB_ZERO      4'h0
`define PLLCG_MUL_ONE       4'h1
`define PLLCG_SW_EDGES      2'h3
`define PLLCG_CNT_ZERO      2'h0
`define PLLCG_CNT_ONE       2'h1
`define PLLCG_RESP_OKAY     2'h0
`define PLLCG_RESP_SLVERR   2'h2
`define PLLCG_DATA_ZERO     32'h00000000
`define PLLCG_PAD_ZERO      24'h000000

`endif

// ==== rtl/pllcg_regs.v ====
// Purpose: PLL clock generator control registers and base clock selector
// Assumes: All inputs synchronous to clk_i; source clocks are sampled levels
// Notes:   AXI4-Lite slave, one write and one read outstanding at a time
`timescale 1ns/1ps
`include "pllcg_defines.vh"

module pllcg_regs (
   // Clock, reset and register bus
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [3:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output wire [1:0]  s_axi_bresp_o,
   output wire        s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [3:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0]  s_axi_rresp_o,
   output wire        s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // Clock sources and loop status
   input  wire        crystal_clock_i,
   input  wire        vco_clock_i,
   input  wire        lock_detect_i,
   input  wire        tracking_i,
   input  wire        stop_i,
   // Base clock and loop controls
   output wire        base_clock_out_o,
   output wire        lock_irq_o,
   output wire        loop_enable_o,
   output wire        auto_bw_o,
   output wire        acq_track_o,
   output wire [3:0]  feedback_multiplier_o,
   output wire [3:0]  vco_range_factor_o
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function is_zero_nib;
      input [3:0] v;
      begin
         is_zero_nib = (v == `PLLCG_NIB_ZERO);
      end
   endfunction

   function [1:0] sat_inc;
      input [1:0] c;
      input       e;
      begin
         if (e && (c != `PLLCG_SW_EDGES)) begin
            sat_inc = c + `PLLCG_CNT_ONE;
         end else begin
            sat_inc = c;
         end
      end
   endfunction

   function is_rise;
      input cur;
      input prev;
      begin
         is_rise = cur && !prev;
      end
   endfunction

   function is_mapped;
      input [3:0] a;
      begin
         if (a == `PLLCG_OFS_CTRL) begin
            is_mapped = 1'b1;
         end else if (a == `PLLCG_OFS_BW) begin
            is_mapped = 1'b1;
         end else if (a == `PLLCG_OFS_PROG) begin
            is_mapped = 1'b1;
         end else begin
            is_mapped = 1'b0;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg         aw_full_q;
   reg  [3:0]  aw_addr_q;
   reg         w_full_q;
   reg  [7:0]  w_data_q;
   reg         w_strb_q;
   reg         bvalid_q;
   reg  [1:0]  bresp_q;
   reg         rvalid_q;
   reg  [31:0] rdata_q;
   reg  [1:0]  rresp_q;
   reg         ie_q;
   reg         flag_q;
   reg         pwr_q;
   reg         sel_q;
   reg         auto_q;
   reg         lock_q;
   reg         track_q;
   reg         man_acq_q;
   reg         xld_q;
   reg  [3:0]  mul_q;
   reg  [3:0]  rng_q;
   reg         xclk_prev_q;
   reg         vclk_prev_q;
   reg         src_q;
   reg         switching_q;
   reg  [1:0]  xcnt_q;
   reg  [1:0]  vcnt_q;
   reg         out_q;
   reg         irq_q;
   reg         en_q;
   reg         acq_out_q;
   reg  [3:0]  mul_out_q;
   reg         aw_rdy_q;
   reg         w_rdy_q;
   reg         ar_rdy_q;

   // ----------------------------------------------------------------
   // Decode and qualifiers
   // ----------------------------------------------------------------
   wire        do_wr     = aw_full_q && w_full_q && !bvalid_q;
   wire        wr_ok     = do_wr && w_strb_q;
   wire        wr_ctrl   = wr_ok && (aw_addr_q == `PLLCG_OFS_CTRL);
   wire        wr_bw     = wr_ok && (aw_addr_q == `PLLCG_OFS_BW);
   wire        wr_prog   = wr_ok && (aw_addr_q == `PLLCG_OFS_PROG);
   wire        ar_take   = s_axi_arvalid_i && !rvalid_q;
   wire        rd_ctrl   = ar_take && (s_axi_araddr_i == `PLLCG_OFS_CTRL);
   wire        xedge     = is_rise(crystal_clock_i, xclk_prev_q);
   wire        vedge     = is_rise(vco_clock_i, vclk_prev_q);
   wire        rng_zero  = is_zero_nib(rng_q);
   wire        lock_d    = auto_q && lock_detect_i;
   wire        acq_view  = auto_q ? track_q : man_acq_q;
   reg         addr_hit;
   reg  [7:0]  rd_byte;

   assign s_axi_awready_o       = aw_rdy_q;
   assign s_axi_wready_o        = w_rdy_q;
   assign s_axi_bvalid_o        = bvalid_q;
   assign s_axi_bresp_o         = bresp_q;
   assign s_axi_arready_o       = ar_rdy_q;
   assign s_axi_rvalid_o        = rvalid_q;
   assign s_axi_rdata_o         = rdata_q;
   assign s_axi_rresp_o         = rresp_q;
   assign base_clock_out_o      = out_q;
   assign lock_irq_o            = irq_q;
   assign loop_enable_o         = en_q;
   assign auto_bw_o             = auto_q;
   assign acq_track_o           = acq_out_q;
   assign feedback_multiplier_o = mul_out_q;
   assign vco_range_factor_o    = rng_q;

   // ----------------------------------------------------------------
   // Read data mux
   // ----------------------------------------------------------------
   always @* begin
      addr_hit = is_mapped(s_axi_araddr_i);
      rd_byte  = 8'h00;
      if (s_axi_araddr_i == `PLLCG_OFS_CTRL) begin
         rd_byte = {ie_q && auto_q,
                    flag_q && auto_q,
                    pwr_q, sel_q, `PLLCG_CTRL_ONES};
      end else if (s_axi_araddr_i == `PLLCG_OFS_BW) begin
         rd_byte = {auto_q, lock_q,
                    acq_view,
                    xld_q && sel_q,
                    `PLLCG_BW_RSVD};
      end else if (s_axi_araddr_i == `PLLCG_OFS_PROG) begin
         rd_byte = {mul_q, rng_q};
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite handshakes
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= `PLLCG_OFS_CTRL;
         w_full_q  <= 1'b0;
         w_data_q  <= 8'h00;
         w_strb_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `PLLCG_RESP_OKAY;
         rvalid_q  <= 1'b0;
         rdata_q   <= `PLLCG_DATA_ZERO;
         rresp_q   <= `PLLCG_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_i[`PLLCG_BUS_BYTE];
            w_strb_q <= s_axi_wstrb_i[`PLLCG_STRB_LOW];
         end
         if (do_wr) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            if (is_mapped(aw_addr_q)) begin
               bresp_q <= `PLLCG_RESP_OKAY;
            end else begin
               bresp_q <= `PLLCG_RESP_SLVERR;
            end
         end else if (s_axi_bready_i) begin
            bvalid_q <= 1'b0;
         end
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {`PLLCG_PAD_ZERO, rd_byte};
            rresp_q  <= addr_hit ? `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
         end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Ready flags
   // ----------------------------------------------------------------
   // Own flops mirror the slot state so every ready port leaves a register
   always @(posedge clk_i) begin
      if (rst_i) begin
         aw_rdy_q <= 1'b1;
         w_rdy_q  <= 1'b1;
         ar_rdy_q <= 1'b1;
      end else begin
         if (do_wr) begin
            aw_rdy_q <= 1'b1;
            w_rdy_q  <= 1'b1;
         end else begin
            if (s_axi_awvalid_i && aw_rdy_q) begin
               aw_rdy_q <= 1'b0;
            end
            if (s_axi_wvalid_i && w_rdy_q) begin
               w_rdy_q <= 1'b0;
            end
         end
         if (ar_take) begin
            ar_rdy_q <= 1'b0;
         end else if (s_axi_rready_i) begin
            ar_rdy_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ie_q   <= 1'b0;
         flag_q <= 1'b0;
         pwr_q  <= 1'b1;
         sel_q  <= 1'b0;
      end else begin
         if (wr_ctrl && auto_q) begin
            ie_q <= w_data_q[`PLLCG_CTRL_IE];
         end
         // Flag set beats the read clear so no lock change is lost
         if (auto_q && (lock_d != lock_q)) begin
            flag_q <= 1'b1;
         end else if (rd_ctrl || !auto_q) begin
            flag_q <= 1'b0;
         end
         if (wr_ctrl) begin
            pwr_q <= w_data_q[`PLLCG_CTRL_PWR] || sel_q;
         end
         // Select checks the old power bit: select cannot rise in the write that raises power
         if (stop_i || rng_zero) begin
            sel_q <= 1'b0;
         end else if (wr_ctrl) begin
            sel_q <= w_data_q[`PLLCG_CTRL_SEL] && pwr_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Bandwidth and programming registers
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         auto_q    <= 1'b0;
         lock_q    <= 1'b0;
         track_q   <= 1'b0;
         man_acq_q <= 1'b0;
         xld_q     <= 1'b0;
         mul_q     <= `PLLCG_MUL_RST;
         rng_q     <= `PLLCG_RNG_RST;
      end else begin
         lock_q  <= lock_d;
         track_q <= auto_q && tracking_i;
         if (wr_bw) begin
            auto_q <= w_data_q[`PLLCG_BW_AUTO];
         end
         // Hidden store is only written in manual mode
         if (wr_bw && !auto_q) begin
            man_acq_q <= w_data_q[`PLLCG_BW_ACQ];
         end
         // A rising crystal edge during the wait proves the reference alive
         if (!sel_q) begin
            xld_q <= 1'b0;
         end else if (wr_bw && w_data_q[`PLLCG_BW_XLD]) begin
            xld_q <= 1'b1;
         end else if (xedge) begin
            xld_q <= 1'b0;
         end
         if (wr_prog && !pwr_q) begin
            mul_q <= w_data_q[`PLLCG_PROG_MUL];
            rng_q <= w_data_q[`PLLCG_PROG_RNG];
         end
      end
   end

   // ----------------------------------------------------------------
   // Base clock selector
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         xclk_prev_q <= 1'b0;
         vclk_prev_q <= 1'b0;
         src_q       <= 1'b0;
         switching_q <= 1'b0;
         xcnt_q      <= `PLLCG_CNT_ZERO;
         vcnt_q      <= `PLLCG_CNT_ZERO;
         out_q       <= 1'b0;
      end else begin
         xclk_prev_q <= crystal_clock_i;
         vclk_prev_q <= vco_clock_i;
         if (switching_q) begin
            xcnt_q <= sat_inc(xcnt_q, xedge);
            vcnt_q <= sat_inc(vcnt_q, vedge);
            if ((xcnt_q == `PLLCG_SW_EDGES) && (vcnt_q == `PLLCG_SW_EDGES)) begin
               switching_q <= 1'b0;
               src_q       <= sel_q;
            end
         end else if (sel_q != src_q) begin
            switching_q <= 1'b1;
            xcnt_q      <= `PLLCG_CNT_ZERO;
            vcnt_q      <= `PLLCG_CNT_ZERO;
         end else if (src_q ? vedge : xedge) begin
            out_q <= !out_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Loop controls and interrupt
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_q     <= 1'b0;
         en_q      <= 1'b0;
         acq_out_q <= 1'b0;
         mul_out_q <= `PLLCG_MUL_RST;
      end else begin
         irq_q     <= flag_q && ie_q && auto_q;
         en_q      <= pwr_q && !rng_zero;
         acq_out_q <= acq_view;
         mul_out_q <= is_zero_nib(mul_q) ? `PLLCG_MUL_ONE : mul_q;
      end
   end

endmodule

// ==== sim/pllcg_regs_chk.sv ====
// Purpose: Port-level checks on the PLL clock generator register block
// Assumes: Bound to pllcg_regs, synchronous active-high reset on clk_i
// Notes:   Source select state is internal, so clock checks use quiet inputs
`timescale 1ns/1ps
`include "pllcg_defines.vh"
module pllcg_regs_chk (
   input wire        clk_i,
   input wire        rst_i,
   input wire [3:0]  s_axi_araddr_i,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire        s_axi_rvalid_o,
   input wire        s_axi_rready_i,
   input wire        crystal_clock_i,
   input wire        vco_clock_i,
   input wire        tracking_i,
   input wire        base_clock_out_o,
   input wire        lock_irq_o,
   input wire        loop_enable_o,
   input wire        auto_bw_o,
   input wire        acq_track_o,
   input wire [3:0]  feedback_multiplier_o,
   input wire [3:0]  vco_range_factor_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Sequences and properties
   // ----------------------------------------------------------------
   sequence s_rd_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   // Six quiet samples cover the edge detector latency
   sequence s_src_quiet;
      ($stable(crystal_clock_i) && $stable(vco_clock_i)) [*6];
   endsequence
   property p_ctrl_ones;
      s_rd_take ##0 (s_axi_araddr_i == `PLLCG_OFS_CTRL) |=> s_axi_rdata_o[3:0] == 4'hF;
   endproperty
   property p_irq_auto;
      lock_irq_o |-> $past(auto_bw_o);
   endproperty
   property p_acq_status;
      (auto_bw_o && $stable(tracking_i)) [*4] |-> acq_track_o == tracking_i;
   endproperty
   property p_out_still;
      s_src_quiet |-> $stable(base_clock_out_o);
   endproperty
   property p_mul_nonzero;
      feedback_multiplier_o != 4'h0;
   endproperty
   property p_prog_frozen;
      loop_enable_o |=> $stable(feedback_multiplier_o) && $stable(vco_range_factor_o);
   endproperty
   property p_range_zero_off;
      (vco_range_factor_o == 4'h0) [*2] |-> !loop_enable_o;
   endproperty
   property p_rd_answer;
      s_rd_take |=> s_axi_rvalid_o;
   endproperty
   property p_rd_done;
      s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o;
   endproperty
   a_ctrl_ones: assert property (p_ctrl_ones)
      else $error("control low bits not all ones");
   a_irq_auto: assert property (p_irq_auto)
      else $error("interrupt raised in manual mode");
   a_acq_status: assert property (p_acq_status)
      else $error("acq bit does not follow loop state");
   a_out_still: assert property (p_out_still)
      else $error("base clock moved without a source edge");
   a_mul_nonzero: assert property (p_mul_nonzero)
      else $error("multiplier shown as zero");
   a_prog_frozen: assert property (p_prog_frozen)
      else $error("programming changed while loop on");
   a_range_zero_off: assert property (p_range_zero_off)
      else $error("loop enabled with zero range");
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer late");
   a_rd_done: assert property (p_rd_done)
      else $error("read valid held after handshake");
endmodule

bind pllcg_regs pllcg_regs_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .crystal_clock_i(crystal_clock_i),
   .vco_clock_i(vco_clock_i), .tracking_i(tracking_i), .base_clock_out_o(base_clock_out_o),
   .lock_irq_o(lock_irq_o), .loop_enable_o(loop_enable_o), .auto_bw_o(auto_bw_o),
   .acq_track_o(acq_track_o), .feedback_multiplier_o(feedback_multiplier_o),
   .vco_range_factor_o(vco_range_factor_o)
);

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the PLL clock generator registers
// Assumes: AXI4-Lite master tasks, source clocks stepped on clk_i edges
// Notes:   Crystal period 8 cycles, VCO period 6 cycles, both stoppable
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
   logic        clk_i, rst_i, awv, wv, bry, arv, rry;
   logic        xc, vc, lk, trk, stp, xrun, vrun;
   logic [3:0]  awa, ara;
   logic [31:0] wd;
   wire         awr, wrdy, bv, arr, rv, bco, irq, len, aut, acq;
   wire  [1:0]  br, rr;
   wire  [31:0] rdo;
   wire  [3:0]  mul, rng;
   integer      n_fail, samples_checked, cyc, tog;
   pllcg_regs uut (
      .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdo), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .crystal_clock_i(xc), .vco_clock_i(vc), .lock_detect_i(lk), .tracking_i(trk),
      .stop_i(stp), .base_clock_out_o(bco), .lock_irq_o(irq), .loop_enable_o(len),
      .auto_bw_o(aut), .acq_track_o(acq), .feedback_multiplier_o(mul),
      .vco_range_factor_o(rng)
   );
   // ----------------------------------------------------------------
   // Clocks, source clocks and timeout
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (xrun && cyc % 4 == 3) xc <= ~xc;
      if (vrun && cyc % 3 == 2) vc <= ~vc;
      if (cyc == 8000) begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr_chk(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      @(posedge clk_i);
      awa <= a;
      wd <= {24'h000000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while ((awv && !awr) || (wv && !wrdy));
      while (!bv) @(posedge clk_i);
      bry <= 1'b0;
      `CHK(br, er)
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
      @(posedge clk_i);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge clk_i); while (!arr);
      arv <= 1'b0;
      do @(posedge clk_i); while (!rv);
      rry <= 1'b0;
      `CHK({rr, rdo}, {er, 24'h000000, e})
   endtask
   // Counts output toggles; a window of 20 source periods allows one edge of slack
   task automatic count(input integer n);
      logic p;
      tog = 0;
      p = bco;
      repeat (n) begin
         @(posedge clk_i);
         if (bco !== p) tog++;
         p = bco;
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_i, xrun, vrun} = 3'h7;
      {awv, wv, bry, arv, rry, xc, vc, lk, trk, stp} = 10'h000;
      {awa, ara, wd} = 40'h0000000000;
      {n_fail, samples_checked, cyc} = 96'h0;
      tick(5);
      rst_i <= 1'b0;
      rd_chk(4'h0, 8'h2F);
      rd_chk(4'h4, 8'h00);
      rd_chk(4'h8, 8'h66);
      rd_chk(4'hC, 8'h00, 2'h2);
      wr_chk(4'hC, 8'h55, 2'h2);
      wr_chk(4'h8, 8'h00);
      rd_chk(4'h8, 8'h66);
      wr_chk(4'h0, 8'hA0);
      rd_chk(4'h0, 8'h2F);
      wr_chk(4'h0, 8'h00);
      wr_chk(4'h0, 8'h10);
      rd_chk(4'h0, 8'h0F);
      wr_chk(4'h8, 8'h40);
      wr_chk(4'h0, 8'h20);
      wr_chk(4'h0, 8'h30);
      rd_chk(4'h0, 8'h2F);
      `CHK(len, 1'b0)
      wr_chk(4'h0, 8'h00);
      wr_chk(4'h8, 8'h04);
      tick(3);
      `CHK(mul, 4'h1)
      wr_chk(4'h8, 8'h44);
      wr_chk(4'h0, 8'h20);
      wr_chk(4'h0, 8'h30);
      wr_chk(4'h0, 8'h10);
      rd_chk(4'h0, 8'h3F);
      `CHK(len, 1'b1)
      `CHK(rng, 4'h4)
      tick(60);
      count(120);
      `CHK(tog >= 19 && tog <= 21, 1'b1)
      wr_chk(4'h4, 8'h10);
      tick(16);
      rd_chk(4'h4, 8'h00);
      xrun <= 1'b0;
      wr_chk(4'h4, 8'h10);
      tick(16);
      rd_chk(4'h4, 8'h10);
      stp <= 1'b1;
      tick(1);
      stp <= 1'b0;
      rd_chk(4'h0, 8'h2F);
      rd_chk(4'h4, 8'h00);
      count(60);
      `CHK(tog, 0)
      xrun <= 1'b1;
      tick(60);
      count(160);
      `CHK(tog >= 19 && tog <= 21, 1'b1)
      wr_chk(4'h4, 8'h20);
      rd_chk(4'h4, 8'h20);
      wr_chk(4'h4, 8'hA0);
      rd_chk(4'h4, 8'h80);
      `CHK(aut, 1'b1)
      trk <= 1'b1;
      wr_chk(4'h0, 8'hA0);
      rd_chk(4'h0, 8'hAF);
      lk <= 1'b1;
      tick(6);
      `CHK(irq, 1'b1)
      rd_chk(4'h4, 8'hE0);
      rd_chk(4'h0, 8'hEF);
      rd_chk(4'h0, 8'hAF);
      tick(2);
      `CHK(irq, 1'b0)
      wr_chk(4'h0, 8'h20);
      lk <= 1'b0;
      tick(6);
      `CHK(irq, 1'b0)
      rd_chk(4'h0, 8'h6F);
      trk <= 1'b0;
      wr_chk(4'h4, 8'h00);
      rd_chk(4'h0, 8'h2F);
      rd_chk(4'h4, 8'h20);
      `CHK(acq, 1'b1)
      `CHK(aut, 1'b0)
      xrun <= 1'b0;
      vrun <= 1'b0;
      tick(20);
      stop_test();
   end
endmodule
